// ---- rps_regs.svh ----
// Timing counts and reset values shared by both ends of the reset link
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH

// Core clock period in ns
`define RPS_CLK_PERIOD_NS      10
// Default PLL settling time model in core cycles
`define RPS_LOCK_CYCLES        64
// Cycles the board holds power-on reset after lock is seen
`define RPS_POR_HOLD_CYCLES    16
// Cycles of stable supply with lock seen required before the board releases resets
`define RPS_SUPPLY_CYCLES      8
// Reset value of the lock output
`define RPS_LOCK_RESET         1'b0

`endif

// ---- rps_pkg.sv ----
// Types shared by both ends of the reset sequencer link
package rps_pkg;

    // Device-side reset sequencer states, one-hot
    typedef enum logic [3:0] {
        RPS_ST_WAIT_LOCK = 4'h1,
        RPS_ST_WAIT_POR  = 4'h2,
        RPS_ST_SYNC      = 4'h4,
        RPS_ST_RUN       = 4'h8
    } rps_dev_state_t;

    // Board-side supervisor states, one-hot
    typedef enum logic [2:0] {
        RPS_BD_POWER_UP = 3'h1,
        RPS_BD_HOLD     = 3'h2,
        RPS_BD_RELEASED = 3'h4
    } rps_board_state_t;

endpackage

// ---- rps_link_if.sv ----
// Reset, lock and test pins between the device and board reset logic
`timescale 1ns/1ns
`default_nettype none
interface rps_link_if;
    logic power_on_reset_in_n;
    logic system_reset_n;
    logic pll_lock;
    logic tap_reset_n;
    logic tap_clock;
    logic tap_mode_select;
    logic tap_serial_in;
    logic tap_serial_out;
    logic bypass_clock;
    logic scan_test_select_n;
    logic float_outputs_n;

    modport device (
        input  power_on_reset_in_n,
        input  system_reset_n,
        output pll_lock,
        input  tap_reset_n,
        input  tap_clock,
        input  tap_mode_select,
        input  tap_serial_in,
        output tap_serial_out,
        input  bypass_clock,
        input  scan_test_select_n,
        input  float_outputs_n
    );

    modport board (
        output power_on_reset_in_n,
        output system_reset_n,
        input  pll_lock,
        output tap_reset_n,
        output tap_clock,
        output tap_mode_select,
        output tap_serial_in,
        input  tap_serial_out,
        output bypass_clock,
        output scan_test_select_n,
        output float_outputs_n
    );
endinterface
`default_nettype wire

// ---- rps_device.sv ----
// Device end: PLL lock report, core reset release and TAP sampling
//
// What this block and the board end do
// RULE_01 - Board holds power-on reset until PLL locks
// RULE_02 - System reset counts only after power-up conditions
// RULE_03 - Drive lock output when PLL locked
// RULE_04 - Test reset low resets the TAP logic
// RULE_05 - Board drives test reset low at power-up
// RULE_06 - TAP clocked and sampled by test clock
// RULE_07 - Reset mid-transaction gives undefined bus protocol
// RULE_08 - Board holds test straps high normally
// RULE_09 - Core reset held until all conditions, synchronous release
`timescale 1ns/1ns
`default_nettype none
`include "rps_regs.svh"
module rps_device #(
    parameter int TAP_IR_WIDTH = 4
) (
    input  wire logic  clk_sys_i,
    input  wire logic  reset_n_i,
    rps_link_if.device link,
    input  wire logic  pll_locked_i,
    input  wire logic  supply_good_i,
    input  wire logic  bus_busy_i,
    output logic       core_reset_n_o,
    output logic       tap_reset_active_o,
    output logic       reset_mid_transfer_o,
    output logic       test_mode_o,
    output logic [TAP_IR_WIDTH-1:0] tap_shift_o
);

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers; first stage feeds only the second
    logic lock_s1;
    logic lock_s2;
    logic por_s1;
    logic por_s2;
    logic sys_s1;
    logic sys_s2;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
            por_s1  <= 1'b0;
            por_s2  <= 1'b0;
            sys_s1  <= 1'b0;
            sys_s2  <= 1'b0;
        end else begin
            lock_s1 <= pll_locked_i;
            lock_s2 <= lock_s1;
            por_s1  <= link.power_on_reset_in_n;
            por_s2  <= por_s1;
            sys_s1  <= link.system_reset_n;
            sys_s2  <= sys_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reset conditions
    wire power_up_ok = supply_good_i & lock_s2;
    // RULE_02 system reset gated
    wire sys_reset_req = por_s2 & power_up_ok & ~sys_s2;
    // RULE_01 relies on board holding POR
    wire por_active = ~por_s2;
    // RULE_09 any condition holds reset
    wire hold_reset = por_active | sys_reset_req | ~power_up_ok;

    rps_pkg::rps_dev_state_t state;
    rps_pkg::rps_dev_state_t next_state;

    ////////////////////////////////////////////////////////////////////
    // Sequencer: wait lock, wait POR release, one sync cycle, run
    always_comb begin
        next_state = state;
        case (state)
            rps_pkg::RPS_ST_WAIT_LOCK: begin
                if (power_up_ok) next_state = rps_pkg::RPS_ST_WAIT_POR;
            end
            rps_pkg::RPS_ST_WAIT_POR: begin
                if (!power_up_ok) next_state = rps_pkg::RPS_ST_WAIT_LOCK;
                else if (!hold_reset) next_state = rps_pkg::RPS_ST_SYNC;
            end
            rps_pkg::RPS_ST_SYNC: begin
                if (hold_reset) next_state = rps_pkg::RPS_ST_WAIT_LOCK;
                else next_state = rps_pkg::RPS_ST_RUN;
            end
            rps_pkg::RPS_ST_RUN: begin
                if (hold_reset) next_state = rps_pkg::RPS_ST_WAIT_LOCK;
            end
            default: next_state = rps_pkg::RPS_ST_WAIT_LOCK;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) state <= rps_pkg::RPS_ST_WAIT_LOCK;
        else state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////
    // Registered outputs
    logic lock_out;
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            lock_out             <= `RPS_LOCK_RESET;
            core_reset_n_o       <= 1'b0;
            reset_mid_transfer_o <= 1'b0;
            test_mode_o          <= 1'b0;
        end else begin
            // RULE_03 report PLL lock
            lock_out       <= lock_s2;
            // RULE_09 synchronous release
            core_reset_n_o <= (next_state == rps_pkg::RPS_ST_RUN);
            // RULE_07 flag undefined protocol; sticky until reset_n_i, supply loss does not clear it
            if (core_reset_n_o && hold_reset && bus_busy_i)
                reset_mid_transfer_o <= 1'b1;
            test_mode_o <= ~(link.bypass_clock & link.scan_test_select_n
                             & link.float_outputs_n);
        end
    end
    assign link.pll_lock = lock_out;

    ////////////////////////////////////////////////////////////////////
    // TAP shift path on the test clock; TAP state machine lives elsewhere
    logic [TAP_IR_WIDTH-1:0] tap_shift;
    logic                    tap_out;
    // RULE_04 asynchronous test reset
    always_ff @(posedge link.tap_clock or negedge link.tap_reset_n) begin
        if (!link.tap_reset_n) begin
            tap_shift <= '0;
        end else if (!link.tap_mode_select) begin
            // RULE_06 sample serial in
            tap_shift <= {link.tap_serial_in, tap_shift[TAP_IR_WIDTH-1:1]};
        end
    end
    // Output changes on the falling edge as the test port expects
    always_ff @(negedge link.tap_clock or negedge link.tap_reset_n) begin
        if (!link.tap_reset_n) tap_out <= 1'b0;
        else tap_out <= tap_shift[0];
    end
    // RULE_06 drive serial out
    assign link.tap_serial_out = tap_out;
    assign tap_shift_o         = tap_shift;
    assign tap_reset_active_o  = ~link.tap_reset_n;

endmodule
`default_nettype wire

// ---- rps_board.sv ----
// Board end: power supervisor driving resets and holding test straps
`timescale 1ns/1ns
`default_nettype none
`include "rps_regs.svh"
module rps_board #(
    parameter int HOLD_CYCLES   = `RPS_POR_HOLD_CYCLES,
    parameter int SUPPLY_CYCLES = `RPS_SUPPLY_CYCLES
) (
    input  wire logic  clk_sys_i,
    input  wire logic  reset_n_i,
    rps_link_if.board  link,
    input  wire logic  supply_good_i,
    input  wire logic  system_reset_req_i,
    input  wire logic  tap_enable_i,
    input  wire logic  tap_clock_i,
    input  wire logic  tap_mode_select_i,
    input  wire logic  tap_serial_in_i,
    output logic       tap_serial_out_o,
    output logic       released_o
);

    rps_pkg::rps_board_state_t state;
    rps_pkg::rps_board_state_t next_state;
    logic [7:0] count;

    ////////////////////////////////////////////////////////////////////
    // Supervisor: wait supply and lock, hold, then release
    wire lock_seen = link.pll_lock & supply_good_i;
    always_comb begin
        next_state = state;
        case (state)
            rps_pkg::RPS_BD_POWER_UP: begin
                if (lock_seen && count >= 8'(SUPPLY_CYCLES))
                    next_state = rps_pkg::RPS_BD_HOLD;
            end
            rps_pkg::RPS_BD_HOLD: begin
                if (!lock_seen) next_state = rps_pkg::RPS_BD_POWER_UP;
                else if (count >= 8'(HOLD_CYCLES))
                    next_state = rps_pkg::RPS_BD_RELEASED;
            end
            rps_pkg::RPS_BD_RELEASED: begin
                if (!supply_good_i) next_state = rps_pkg::RPS_BD_POWER_UP;
            end
            default: next_state = rps_pkg::RPS_BD_POWER_UP;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state <= rps_pkg::RPS_BD_POWER_UP;
            count <= 8'h00;
        end else begin
            state <= next_state;
            if (next_state != state || !lock_seen) count <= 8'h00;
            else if (count != 8'hFF) count <= count + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // RULE_01 hold POR until locked
    wire released = (state == rps_pkg::RPS_BD_RELEASED);
    assign link.power_on_reset_in_n = released;
    // RULE_07 caller must avoid mid-transaction reset requests
    assign link.system_reset_n      = ~(released & system_reset_req_i);
    // RULE_05 test reset low until released and used
    assign link.tap_reset_n         = released & tap_enable_i;
    assign link.tap_clock           = tap_clock_i & tap_enable_i;
    assign link.tap_mode_select     = tap_mode_select_i;
    assign link.tap_serial_in       = tap_serial_in_i;
    // RULE_08 test straps held high
    assign link.bypass_clock        = 1'b1;
    assign link.scan_test_select_n  = 1'b1;
    assign link.float_outputs_n     = 1'b1;
    assign tap_serial_out_o         = link.tap_serial_out;
    assign released_o               = released;

endmodule
`default_nettype wire

// ---- rps_props.sv ----
// Concurrent checks on the reset link between device and board ends
`timescale 1ns/1ns
`default_nettype none
module rps_props (
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    input  wire logic pll_locked_i,
    input  wire logic power_on_reset_in_n,
    input  wire logic system_reset_n,
    input  wire logic pll_lock,
    input  wire logic tap_reset_n,
    input  wire logic tap_clock,
    input  wire logic tap_mode_select,
    input  wire logic tap_serial_in,
    input  wire logic tap_serial_out,
    input  wire logic bypass_clock,
    input  wire logic scan_test_select_n,
    input  wire logic float_outputs_n
);
    ////////////////////////////////////////////////////////////////////////
    // Board side: power-on reset only after a seen lock
    AST_POR_AFTER_LOCK: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i) $rose(power_on_reset_in_n) |-> $past(pll_lock))
        else $error("power-on reset released without lock");
    AST_POR_HELD: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i) !pll_lock |-> !power_on_reset_in_n)
        else $error("power-on reset high while unlocked");
    // System reset stays idle while power-on reset is held
    AST_SYS_MASKED: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i) !power_on_reset_in_n |-> system_reset_n)
        else $error("system reset driven during power-up");
    // Two sync stages plus a register: lock must follow within 4 edges
    AST_LOCK_RISE: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i) $rose(pll_locked_i) |-> ##[1:4] pll_lock)
        else $error("lock output late on rise");
    AST_LOCK_FALL: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i) $fell(pll_locked_i) |-> ##[1:4] !pll_lock)
        else $error("lock output late on fall");
    AST_TAP_PWRUP: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i) !power_on_reset_in_n |-> !tap_reset_n)
        else $error("test reset released during power-up");
    AST_STRAPS: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        bypass_clock && scan_test_select_n && float_outputs_n)
        else $error("test strap low in normal operation");
    // Four shifts carry a bit from serial in to serial out
    AST_TAP_SHIFT: assert property (@(posedge tap_clock)
        disable iff (!tap_reset_n) (!tap_mode_select) [*4]
        |=> tap_serial_out == $past(tap_serial_in, 4))
        else $error("serial out does not match shifted input");
    COV_POR: cover property (@(posedge clk_sys_i) $rose(power_on_reset_in_n));
    COV_SYS: cover property (@(posedge clk_sys_i) $fell(system_reset_n));
    COV_TAP: cover property (@(posedge clk_sys_i) $fell(tap_reset_n));
endmodule
`default_nettype wire

// ---- reset_pll_lock_sequencer_test.sv ----
// Testbench joining device and board ends of the reset link
`timescale 1ns/1ns
`default_nettype none
module reset_pll_lock_sequencer_test;
    logic       clk_sys_i, reset_n_i, pll_locked_i, supply_good_i;
    logic       bus_busy_i, system_reset_req_i, tap_enable_i;
    logic       tap_clock_i, tap_mode_select_i, tap_serial_in_i;
    logic       core_reset_n_o, tap_reset_active_o, reset_mid_transfer_o;
    logic       test_mode_o, tap_serial_out_o, released_o;
    logic [3:0] tap_shift_o;
    int         fails, n_checks, i;
    // Serial pattern shifted into the test port, first bit in bit 0
    logic [4:0] tap_pat = 5'h0B;

    rps_link_if link ();
    rps_device i_rps_device (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .link(link), .pll_locked_i(pll_locked_i),
        .supply_good_i(supply_good_i), .bus_busy_i(bus_busy_i),
        .core_reset_n_o(core_reset_n_o),
        .tap_reset_active_o(tap_reset_active_o),
        .reset_mid_transfer_o(reset_mid_transfer_o),
        .test_mode_o(test_mode_o), .tap_shift_o(tap_shift_o));
    // Short hold counts keep the power-up walk brief
    rps_board #(.HOLD_CYCLES(2), .SUPPLY_CYCLES(1)) i_rps_board (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .link(link),
        .supply_good_i(supply_good_i),
        .system_reset_req_i(system_reset_req_i),
        .tap_enable_i(tap_enable_i), .tap_clock_i(tap_clock_i),
        .tap_mode_select_i(tap_mode_select_i),
        .tap_serial_in_i(tap_serial_in_i),
        .tap_serial_out_o(tap_serial_out_o), .released_o(released_o));
    rps_props i_rps_props (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .pll_locked_i(pll_locked_i),
        .power_on_reset_in_n(link.power_on_reset_in_n),
        .system_reset_n(link.system_reset_n), .pll_lock(link.pll_lock),
        .tap_reset_n(link.tap_reset_n), .tap_clock(link.tap_clock),
        .tap_mode_select(link.tap_mode_select),
        .tap_serial_in(link.tap_serial_in),
        .tap_serial_out(link.tap_serial_out),
        .bypass_clock(link.bypass_clock),
        .scan_test_select_n(link.scan_test_select_n),
        .float_outputs_n(link.float_outputs_n));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // Bounded wait for the core to leave reset
    task automatic wait_core();
        for (i = 0; i < 60 && core_reset_n_o !== 1'b1; i++) cyc(1);
    endtask
    // One test clock pulse; the clock stands still between bits
    task automatic tap_bit(input logic b);
        tap_mode_select_i <= 1'b0;
        tap_serial_in_i <= b;
        cyc(1);
        tap_clock_i <= 1'b1;
        cyc(1);
        tap_clock_i <= 1'b0;
        cyc(1);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // Watchdog: the sequence needs well under 500 cycles
    initial begin
        cyc(3000);
        fails++;
        print_verdict();
    end
    initial begin
        {reset_n_i, pll_locked_i, bus_busy_i, system_reset_req_i} = 4'h0;
        {tap_enable_i, tap_clock_i, tap_serial_in_i} = 3'h0;
        supply_good_i = 1'b1;
        tap_mode_select_i = 1'b1;
        cyc(16);
        reset_n_i <= 1'b1;
        cyc(30);
        chk(4'(link.power_on_reset_in_n), 4'h0);
        chk(4'(core_reset_n_o), 4'h0);
        chk(4'(tap_reset_active_o), 4'h1);
        chk(4'(released_o), 4'h0);
        pll_locked_i <= 1'b1;
        wait_core();
        chk(4'(link.pll_lock), 4'h1);
        chk(4'(core_reset_n_o), 4'h1);
        chk(4'(test_mode_o), 4'h0);
        chk(4'(released_o), 4'h1);
        $display("test power_up done");
        system_reset_req_i <= 1'b1;
        cyc(8);
        chk(4'(link.system_reset_n), 4'h0);
        chk(4'(core_reset_n_o), 4'h0);
        chk(4'(reset_mid_transfer_o), 4'h0);
        system_reset_req_i <= 1'b0;
        wait_core();
        chk(4'(core_reset_n_o), 4'h1);
        $display("test system_reset done");
        bus_busy_i <= 1'b1;
        cyc(2);
        system_reset_req_i <= 1'b1;
        cyc(8);
        chk(4'(reset_mid_transfer_o), 4'h1);
        {system_reset_req_i, bus_busy_i} <= 2'h0;
        wait_core();
        $display("test mid_transfer done");
        tap_enable_i <= 1'b1;
        cyc(3);
        chk(4'(tap_reset_active_o), 4'h0);
        for (int k = 0; k < 5; k++) tap_bit(tap_pat[k]);
        chk(tap_shift_o, 4'h5);
        chk(4'(tap_serial_out_o), 4'h1);
        tap_mode_select_i <= 1'b1;
        tap_enable_i <= 1'b0;
        cyc(3);
        chk(4'(tap_reset_active_o), 4'h1);
        chk(tap_shift_o, 4'h0);
        $display("test tap done");
        {supply_good_i, pll_locked_i} <= 2'h0;
        cyc(6);
        chk(4'(link.power_on_reset_in_n), 4'h0);
        chk(4'(link.pll_lock), 4'h0);
        chk(4'(core_reset_n_o), 4'h0);
        chk(4'(released_o), 4'h0);
        $display("test supply_loss done");
        print_verdict();
    end
endmodule
`default_nettype wire
